// *** rtl/otp_pkg.sv ***
// Package with the map, field positions and sizes of the OTP program control block
package otp_pkg;
  localparam logic [31:0] OTP_CTRL_ADDR   = 32'h0000_0007 << 2;
  localparam logic [31:0] OTP_OPT_ADDR    = 32'h0000_1efe << 2;
  localparam logic [31:0] OTP_ARRAY_BASE  = 32'h0001_0000;
  localparam logic [31:0] OTP_ARRAY_LIMIT = 32'h0001_8000;
  localparam logic [31:0] OTP_PROG_BASE   = 32'h0000_0200;
  localparam logic [31:0] OTP_SEC_BASE    = 32'h0000_0000;
  localparam logic [31:0] OTP_SEC_BYTES   = 32'h0000_0100;
  localparam logic [31:0] OTP_TOTAL_BYTES = 32'h0000_183e;
  localparam logic [12:0] OTP_VEC_LO      = 13'h1ff2;
  localparam logic [12:0] OTP_VEC_HI      = 13'h1fff;
  localparam int          OTP_BIT_PPT     = 6;
  localparam int          OTP_BIT_LAT     = 5;
  localparam int          OTP_BIT_PGM     = 4;
  localparam int          OTP_BIT_CLK     = 3;
  localparam int          OTP_BIT_PROT    = 6;
  localparam logic [7:0]  OTP_OPT_MASK    = 8'h5f;
  localparam logic [7:0]  OTP_OPT_INIT    = 8'h00;
  localparam logic [7:0]  OTP_ERASED      = 8'h00;
  localparam int          OTP_GROUP       = 4;
  typedef enum logic [1:0] {
    OTP_IDLE  = 2'b00,
    OTP_LATCH = 2'b01,
    OTP_PROG  = 2'b10
  } otp_mode_e;
endpackage

// *** rtl/otp_eprom_program_control.sv ***
// OTP program array with latch, program, protect and option register over APB
//
// Chosen here: the APB register port.
`timescale 1ns/1ns
// What this block does
// - Holds 6206 one-time-programmable bytes including the user vector area.
// - Protect bit blocks main array only; 256-byte secondary array stays programmable.
// - Vector table sits in the top fourteen bytes, 1ff2 through 1fff.
// - Unprogrammed bytes read back as zero.
// - While latch enable is set the array gives no valid instruction fetch.
// - Programming a byte only adds one bits, never clears them.
// - Up to four bytes program together only within one four-byte group.
// - Reset loads the protect status copy from the option protect bit.
// - Option bits are nonvolatile; reset does not change them.
// - Latch enable set, program enable clear: array writes latch address and data.
// - Program enable sets only after latch enable and at least one latched byte.
// - Software cannot clear program enable; clearing latch enable clears it.
// - Stop, power-on and external reset clear latch enable.
module otp_eprom_program_control
  import otp_pkg::*;
#(
  parameter int ARRAY_BYTES = 6206
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        stopMode,
  input  wire logic        bootloaderMode,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fetchReq,
  input  wire logic [12:0] fetchAddr,
  output logic      [7:0]  fetchData,
  output logic             fetchValid,
  output logic             programSupplyPin,
  output logic             externalClockOutput
);

  // Array and option byte are not reset: they model nonvolatile cells that start erased
  logic [7:0] cells [ARRAY_BYTES] = '{default: OTP_ERASED};
  logic [7:0] optCells = OTP_OPT_INIT;

  // Vector bytes sit at the top of the map, above the gap behind the main array
  localparam int VecBytes = int'(OTP_VEC_HI - OTP_VEC_LO) + 1;

  typedef struct packed {
    logic        latchEn;
    logic        pgmEn;
    logic        protCopy;
    logic        clkOut;
    logic        loaded;
    logic        booted;
    otp_mode_e   mode;
    logic [3:0]  byteValid;
    logic [10:0] groupAddr;
    logic [31:0] latchData;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic [7:0]  fdata;
    logic        fvalid;
    logic        supply;
  } otp_state_s;

  otp_state_s st_r, st_nxt;
  logic       wrDone, rdDone, inArray, burn, protNow;
  logic [12:0] aIdx;
  logic [10:0] burnGroup;
  logic [3:0]  burnMask;
  logic [31:0] burnData;
  int          burnIdx [OTP_GROUP];

  // Returns -1 for addresses that hold no cell; those read erased and never burn
  function automatic int cellIdx(input logic [12:0] addr);
    if (addr >= OTP_VEC_LO) begin
      cellIdx = ARRAY_BYTES - VecBytes + int'(addr - OTP_VEC_LO);
    end else if (int'(addr) < ARRAY_BYTES - VecBytes) begin
      cellIdx = int'(addr);
    end else begin
      cellIdx = -1;
    end
  endfunction

  // Missing cells read like erased ones, so a stray read never shows stale data
  function automatic logic [7:0] readCell(input logic [12:0] addr);
    int idx;
    idx = cellIdx(addr);
    if (idx >= 0) begin
      readCell = cells[idx];
    end else begin
      readCell = OTP_ERASED;
    end
  endfunction

  assign aIdx    = paddr[12:0];
  assign inArray = paddr >= OTP_ARRAY_BASE && paddr < OTP_ARRAY_LIMIT;
  assign protNow = optCells[OTP_BIT_PROT];
  assign wrDone  = psel && penable && pwrite && !st_r.ready;
  assign rdDone  = psel && penable && !pwrite && !st_r.ready;
  // Protection is checked per group; a mixed group is refused as a whole
  assign burn    = st_r.mode == OTP_PROG && st_r.loaded
                   && (!protNow || st_r.groupAddr < OTP_SEC_BYTES[12:2]);

  // Cell slots of the held group, worked out once per cycle
  always_comb begin
    for (int i = 0; i < OTP_GROUP; i++) begin
      burnIdx[i] = cellIdx({st_r.groupAddr, 2'(i)});
    end
  end

  always_comb begin
    st_nxt          = st_r;
    st_nxt.ready    = 1'b0;
    st_nxt.err      = 1'b0;
    st_nxt.fvalid   = 1'b0;
    st_nxt.supply   = st_r.pgmEn;
    // Copy is refreshed once after every reset; the option cell itself never resets
    if (!st_r.booted) begin
      st_nxt.booted   = 1'b1;
      st_nxt.protCopy = protNow;
    end
    if (psel && penable && !st_r.ready) begin
      st_nxt.ready = 1'b1;
    end
    if (wrDone) begin
      if (paddr == OTP_CTRL_ADDR) begin
        st_nxt.clkOut  = pwdata[OTP_BIT_CLK];
        st_nxt.latchEn = pwdata[OTP_BIT_LAT];
        if (!pwdata[OTP_BIT_LAT]) begin
          st_nxt.pgmEn     = 1'b0;
          st_nxt.loaded    = 1'b0;
          st_nxt.byteValid = 4'h0;
        end else if (pwdata[OTP_BIT_PGM] && st_r.latchEn && st_r.loaded) begin
          st_nxt.pgmEn = 1'b1;
        end
      end else if (paddr == OTP_OPT_ADDR) begin
        st_nxt.err = !bootloaderMode;
      end else if (inArray) begin
        if (st_r.latchEn && !st_r.pgmEn) begin
          // Bytes outside the held group are refused rather than mixing groups
          if (st_r.loaded && aIdx[12:2] != st_r.groupAddr) begin
            st_nxt.err = 1'b1;
          end else begin
            st_nxt.loaded    = 1'b1;
            st_nxt.groupAddr = aIdx[12:2];
            st_nxt.byteValid[aIdx[1:0]] = 1'b1;
            st_nxt.latchData[aIdx[1:0]*8 +: 8] = pwdata[7:0];
          end
        end else begin
          st_nxt.err = 1'b1;
        end
      end else begin
        st_nxt.err = 1'b1;
      end
    end
    if (rdDone) begin
      st_nxt.rdata = 32'h0;
      if (paddr == OTP_CTRL_ADDR) begin
        st_nxt.rdata[OTP_BIT_PPT] = st_r.protCopy;
        st_nxt.rdata[OTP_BIT_LAT] = st_r.latchEn;
        st_nxt.rdata[OTP_BIT_PGM] = st_r.pgmEn;
        st_nxt.rdata[OTP_BIT_CLK] = st_r.clkOut;
      end else if (paddr == OTP_OPT_ADDR) begin
        st_nxt.rdata[7:0] = optCells & OTP_OPT_MASK;
      end else if (inArray) begin
        st_nxt.rdata[7:0] = st_r.latchEn ? OTP_ERASED : readCell(aIdx);
      end else begin
        st_nxt.err = 1'b1;
      end
    end
    if (fetchReq) begin
      st_nxt.fdata  = readCell(fetchAddr);
      st_nxt.fvalid = !st_r.latchEn;
    end
    if (stopMode) begin
      st_nxt.latchEn   = 1'b0;
      st_nxt.pgmEn     = 1'b0;
      st_nxt.loaded    = 1'b0;
      st_nxt.byteValid = 4'h0;
    end
    // Mode is derived last so it always agrees with the enable bits being stored
    case ({st_nxt.latchEn, st_nxt.pgmEn})
      2'b10:   st_nxt.mode = OTP_LATCH;
      2'b11:   st_nxt.mode = OTP_PROG;
      default: st_nxt.mode = OTP_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign burnGroup = st_r.groupAddr;
  assign burnMask  = st_r.byteValid;
  assign burnData  = st_r.latchData;

  // Array and options have no reset: they survive every reset
  always_ff @(posedge clk) begin
    if (burn) begin
      for (int i = 0; i < OTP_GROUP; i++) begin
        if (burnMask[i] && burnIdx[i] >= 0) begin
          cells[burnIdx[i]] <= cells[burnIdx[i]] | burnData[i*8 +: 8];
        end
      end
    end
    if (wrDone && paddr == OTP_OPT_ADDR && bootloaderMode) begin
      optCells <= optCells | (pwdata[7:0] & OTP_OPT_MASK);
    end
  end

  // Every output is a field of the state register
  assign prdata              = st_r.rdata;
  assign pready              = st_r.ready;
  assign pslverr             = st_r.err;
  assign fetchData           = st_r.fdata;
  assign fetchValid          = st_r.fvalid;
  assign programSupplyPin    = st_r.supply;
  assign externalClockOutput = st_r.clkOut;

  // Control-state checks plus the option-byte hold; array contents are checked against the bench model
  AST_PGM_NEEDS_LATCH: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_r.pgmEn |-> st_r.latchEn && st_r.loaded)
    else $error("program enable without latch");

  AST_LAT_CLEAR_PGM: assert property (
    @(posedge clk) disable iff (sys_rst)
    wrDone && paddr == OTP_CTRL_ADDR && !pwdata[OTP_BIT_LAT] |=> !st_r.pgmEn)
    else $error("pgm kept");

  AST_STOP_CLEARS: assert property (
    @(posedge clk) disable iff (sys_rst)
    stopMode |=> !st_r.latchEn && !st_r.pgmEn)
    else $error("stop kept latch");

  AST_NO_FETCH: assert property (
    @(posedge clk) disable iff (sys_rst)
    fetchReq && st_r.latchEn |=> !fetchValid)
    else $error("fetch valid while latched");

  AST_ONE_GROUP: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_r.loaded && wrDone && inArray && st_r.latchEn && !st_r.pgmEn
    && aIdx[12:2] != st_r.groupAddr |=> pslverr)
    else $error("group mix accepted");

  AST_LATCH_WRITE: assert property (
    @(posedge clk) disable iff (sys_rst)
    wrDone && inArray && st_r.latchEn && !st_r.pgmEn && !st_r.loaded && !stopMode
    |=> st_r.loaded && st_r.byteValid != 4'h0)
    else $error("byte not latched");

  AST_SUPPLY: assert property (
    @(posedge clk) disable iff (sys_rst)
    programSupplyPin |-> $past(st_r.pgmEn))
    else $error("supply early");

  AST_PROT_BURN: assert property (
    @(posedge clk) disable iff (sys_rst)
    burn && protNow |-> st_r.groupAddr < OTP_SEC_BYTES[12:2])
    else $error("protected burn");

  AST_SEC_BURN: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_r.mode == OTP_PROG && st_r.loaded && st_r.groupAddr < OTP_SEC_BYTES[12:2] |-> burn)
    else $error("secondary group not burnt");

  AST_VEC_TOP: assert property (
    @(posedge clk) disable iff (sys_rst)
    fetchReq && fetchAddr >= OTP_VEC_LO |-> cellIdx(fetchAddr) >= ARRAY_BYTES - VecBytes)
    else $error("vector outside top cells");

  AST_LATCHED_READ: assert property (
    @(posedge clk) disable iff (sys_rst)
    rdDone && inArray && st_r.latchEn |=> prdata == 32'h0)
    else $error("array read while latched");

  AST_FETCH_OPEN: assert property (
    @(posedge clk) disable iff (sys_rst)
    fetchReq && !st_r.latchEn |=> fetchValid)
    else $error("fetch refused while unlatched");

  AST_PROT_COPY: assert property (
    @(posedge clk) disable iff (sys_rst)
    !st_r.booted |=> st_r.protCopy == $past(protNow))
    else $error("protect copy not loaded");

  AST_OPT_KEEP: assert property (
    @(posedge clk)
    !(wrDone && paddr == OTP_OPT_ADDR && bootloaderMode) |=> $stable(optCells))
    else $error("option byte changed");

  AST_NO_LATCH_ERR: assert property (
    @(posedge clk) disable iff (sys_rst)
    wrDone && inArray && !st_r.latchEn |=> pslverr && !st_r.loaded)
    else $error("array write taken without latch");

  AST_BYTE_KEPT: assert property (
    @(posedge clk) disable iff (sys_rst)
    wrDone && inArray && st_r.latchEn && !st_r.pgmEn && !stopMode
    && !(st_r.loaded && aIdx[12:2] != st_r.groupAddr)
    |=> st_r.byteValid[$past(aIdx[1:0])])
    else $error("latched byte not marked");

  AST_MODE_PROG: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_r.mode == OTP_PROG |-> st_r.pgmEn && st_r.latchEn)
    else $error("program mode without enables");

  AST_PGM_STICKY: assert property (
    @(posedge clk) disable iff (sys_rst)
    st_r.pgmEn && !stopMode && !(wrDone && paddr == OTP_CTRL_ADDR && !pwdata[OTP_BIT_LAT])
    |=> st_r.pgmEn)
    else $error("program enable dropped");

  AST_SUPPLY_DROP: assert property (
    @(posedge clk) disable iff (sys_rst)
    !st_r.pgmEn |=> !programSupplyPin)
    else $error("supply kept");
endmodule

// *** verif/otp_supply_switch.sv ***
// Model of the board switch that raises the programming supply
`timescale 1ns/1ns
module otp_supply_switch (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic programSupplyPin,
  output logic      supplyHigh
);
  // Follows the pin only after it rises, so the array never sees high supply early
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) supplyHigh <= 1'b0;
    else supplyHigh <= programSupplyPin;
  end
endmodule

// *** verif/otp_eprom_program_control_bench.sv ***
// Self-checking bench for the OTP program control block
`timescale 1ns/1ns
module otp_eprom_program_control_bench;
  import otp_pkg::*;
  logic        clk, sys_rst, stopMode, bootloaderMode, psel, penable, pwrite, fetchReq;
  logic        pready, pslverr, fetchValid, programSupplyPin, extClk, supplyHigh, err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [12:0] fetchAddr;
  logic [7:0]  fetchData;
  int          errors, cmp_count;
  logic [7:0]  mem [int];
  logic        prot;
  otp_eprom_program_control otp_eprom_program_control_inst (.clk(clk), .sys_rst(sys_rst),
    .stopMode(stopMode), .bootloaderMode(bootloaderMode), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fetchReq(fetchReq), .fetchAddr(fetchAddr), .fetchData(fetchData),
    .fetchValid(fetchValid), .programSupplyPin(programSupplyPin), .externalClockOutput(extClk));
  otp_supply_switch otp_supply_switch_inst (.clk(clk), .sys_rst(sys_rst),
    .programSupplyPin(programSupplyPin), .supplyHigh(supplyHigh));
  task automatic complete_run;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      complete_run();
    end else begin
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
    end
  endtask
  // Erased cells of the model read as zero
  function automatic logic [7:0] mread(int i);
    return mem.exists(i) ? mem[i] : 8'h00;
  endfunction
  task automatic rdchk(int i);
    apb(1'b0, OTP_ARRAY_BASE + i, 32'h0);
    chk("array", {24'h0, mread(i)}, rd);
  endtask
  task automatic fetch(int i, logic v);
    @(posedge clk);
    {fetchReq, fetchAddr} <= {1'b1, i[12:0]};
    @(posedge clk);
    fetchReq <= 1'b0;
    @(negedge clk);
    chk("fetchValid", {31'h0, v}, {31'h0, fetchValid});
    if (v) chk("fetchData", {24'h0, mread(i)}, {24'h0, fetchData});
  endtask
  task automatic prog(int base);
    logic [7:0] d [4];
    apb(1'b1, OTP_CTRL_ADDR, 32'h20);
    for (int k = 0; k < 4; k++) begin
      d[k] = 8'($urandom);
      apb(1'b1, OTP_ARRAY_BASE + base + k, {24'h0, d[k]});
      chk("err", 32'h0, {31'h0, err});
    end
    apb(1'b1, OTP_ARRAY_BASE + base + 4, 32'h5a);
    chk("err", 32'h1, {31'h0, err});
    fetch(base, 1'b0);
    apb(1'b1, OTP_CTRL_ADDR, 32'h30);
    repeat (3) @(negedge clk);
    chk("supply", 32'h1, {31'h0, supplyHigh});
    apb(1'b1, OTP_CTRL_ADDR, 32'h20);
    apb(1'b0, OTP_CTRL_ADDR, 32'h0);
    chk("ctrl", {25'h0, prot, 6'h30}, rd);
    apb(1'b1, OTP_CTRL_ADDR, 32'h0);
    apb(1'b0, OTP_CTRL_ADDR, 32'h0);
    chk("ctrl", {25'h0, prot, 6'h00}, rd);
    for (int k = 0; k < 4; k++) begin
      if (!(prot && base + k >= 256)) mem[base + k] = mread(base + k) | d[k];
      rdchk(base + k);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {sys_rst, stopMode, bootloaderMode, psel, penable, pwrite, fetchReq, prot} = 8'h80;
    {paddr, pwdata, fetchAddr, errors, cmp_count} = '0;
    void'($urandom(78603));
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    apb(1'b0, OTP_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b0, 32'h4, 32'h0);
    chk("err", 32'h1, {31'h0, err});
    rdchk(32'h300 + ($urandom % 64));
    apb(1'b1, OTP_ARRAY_BASE + 8, 32'h1);
    chk("err", 32'h1, {31'h0, err});
    apb(1'b1, OTP_CTRL_ADDR, 32'h18);
    apb(1'b0, OTP_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h8, rd);
    chk("clkout", 32'h1, {31'h0, extClk});
    apb(1'b1, OTP_CTRL_ADDR, 32'h30);
    apb(1'b0, OTP_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h20, rd);
    apb(1'b1, OTP_CTRL_ADDR, 32'h0);
    prog(32'h200);
    prog(32'h200);
    prog(32'h1ffc);
    fetch(32'h1ffc, 1'b1);
    apb(1'b1, OTP_CTRL_ADDR, 32'h20);
    stopMode <= 1'b1;
    @(posedge clk);
    stopMode <= 1'b0;
    apb(1'b0, OTP_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h0, rd);
    apb(1'b1, OTP_OPT_ADDR, 32'h40);
    chk("err", 32'h1, {31'h0, err});
    bootloaderMode <= 1'b1;
    apb(1'b1, OTP_OPT_ADDR, 32'h40);
    bootloaderMode <= 1'b0;
    // Mid-run reset must keep the option byte and reload the protect copy
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    prot = 1'b1;
    apb(1'b0, OTP_OPT_ADDR, 32'h0);
    chk("option", 32'h40, rd);
    apb(1'b0, OTP_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h40, rd);
    prog(32'h400);
    prog(32'h10);
    complete_run();
  end
endmodule
